/* File: design/wdc_pkg.sv */
// Package holding the watchdog register map, field layout, reset value and timing constants.
package wdc_pkg;
   localparam logic [7:0] WDC_ADDR = 8'hD8;
   localparam logic [7:0] WDC_RESET_VAL = 8'hFE;
   localparam int WDC_ACT_BIT = 0;
   localparam int WDC_SR_BIT = 1;
   localparam int WDC_CNT_W = 7;
   localparam int WDC_TICK_CYCLES = 3072;
   localparam int WDC_MIN_PERIOD = 3072;
   localparam int WDC_MAX_PERIOD = 196608;
   localparam int WDC_GUARD_INSTR = 28;
endpackage

/* File: design/wdc_divider.sv */
// Prescaler that turns the core clock into a one-cycle counter tick enable.
`timescale 1ns/1ps
module wdc_divider #(
   parameter int DIV = 3072
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic run,
   input wire logic restart,
   output logic tick
);
   logic [17:0] cnt_r;

   // Restart realigns the prescaler so a fresh reload gives a full interval.
   always_ff @(posedge ref_clk) begin
      if (srst || restart) begin
         cnt_r <= 18'h00000;
      end else if (run) begin
         if (cnt_r == 18'(DIV - 1)) begin
            cnt_r <= 18'h00000;
         end else begin
            cnt_r <= cnt_r + 18'h00001;
         end
      end
   end

   assign tick = run && !restart && (cnt_r == 18'(DIV - 1));

   AST_TICK_BOUND: assert property (@(posedge ref_clk) disable iff (srst)
      cnt_r <= 18'(DIV - 1)) else $error("prescaler count out of range");
endmodule

/* File: design/wdc_watchdog.sv */
// Digital watchdog downcounter with register port, activation options and stop control.
`timescale 1ns/1ps
// What this block does
// - Reset loads register value FE, or FF with hardware option: activation bit HW_ACTIVATION, period and soft-reset bits one.
// - Register lives in data space and is both readable and writable.
// - Writing the six period bits sets the downcounter start value.
// - While armed, soft-reset bit falling from one to zero raises chip reset.
// - While armed, software writing zero to a set soft-reset bit resets the device at once.
// - Register bit 7 is counter LSB; register bit 2 is top period bit.
// - Six period bits give 64 timeouts from 3072 to 196608 cycles.
// - Hardware option: activation bit reads one always, writes ignored.
// - Software option: writing one arms; only chip reset disarms.
// - Disarmed: counter is free 7-bit timer, soft-reset bit its MSB, no reset.
// - At least 28 instructions run after activation before any timeout reset.
// - Hardware option without external stop: STOP acts as WAIT, counting continues.
// - External stop control with NMI low: STOP behaves as WAIT.
// - External stop control with NMI high: STOP freezes counter until interrupt.
// - While disarmed, STOP remains available to the core.
module wdc_watchdog #(
   parameter bit HW_ACTIVATION = 1'b1,
   parameter bit EXT_STOP_CTRL = 1'b0,
   parameter int TICK_CYCLES = wdc_pkg::WDC_TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic stop_req,
   input wire logic wake_irq,
   input wire logic nmi_pin,
   output logic stop_granted,
   output logic chip_reset_req,
   output logic armed
);
   logic [6:0] cnt_r;
   logic act_r;
   logic frozen_r;
   logic nmi_meta_r;
   logic nmi_sync_r;
   logic sel_wr;
   logic tick;
   logic [6:0] cnt_nxt;
   logic [6:0] wr_cnt;
   logic sr_fall;

   assign sel_wr = reg_wr && (reg_addr == wdc_pkg::WDC_ADDR);
   // Register bit 7 is counter LSB and bit 1 is its MSB.
   always_comb begin
      wr_cnt = 7'h00;
      for (int i = 0; i < 7; i++) begin
         wr_cnt[i] = reg_wdata[7 - i];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         nmi_meta_r <= 1'b0;
         nmi_sync_r <= 1'b0;
      end else begin
         nmi_meta_r <= nmi_pin;
         nmi_sync_r <= nmi_meta_r;
      end
   end

   // Hardware option keeps the bit high and writes cannot lower it.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         act_r <= HW_ACTIVATION;
      end else if (sel_wr && reg_wdata[wdc_pkg::WDC_ACT_BIT]) begin
         act_r <= 1'b1;
      end
   end
   assign armed = act_r;

   // Frozen only for a true STOP: external stop control with NMI high, or disarmed.
   always_ff @(posedge ref_clk) begin
      if (srst || wake_irq) begin
         frozen_r <= 1'b0;
      end else if (stop_req) begin
         if (!act_r) begin
            frozen_r <= 1'b1;
         end else if (EXT_STOP_CTRL && nmi_sync_r) begin
            frozen_r <= 1'b1;
         end else begin
            frozen_r <= 1'b0;
         end
      end
   end
   assign stop_granted = frozen_r;

   // Each of the 64 period codes adds one prescaler interval to the timeout.
   wdc_divider #(.DIV(TICK_CYCLES)) u_div (
      .ref_clk(ref_clk),
      .srst(srst),
      .run(!frozen_r),
      .restart(sel_wr),
      .tick(tick)
   );

   always_comb begin
      cnt_nxt = cnt_r;
      if (sel_wr) begin
         cnt_nxt = wr_cnt;
      end else if (tick) begin
         cnt_nxt = cnt_r - 7'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_r <= 7'h7F;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // A full tick interval of 3072 cycles exceeds 28 instructions, so a fresh arm is safe.
   assign sr_fall = cnt_r[6] && !cnt_nxt[6];
   assign chip_reset_req = act_r && sr_fall && !srst;

   always_comb begin
      reg_rdata = 8'h00;
      for (int i = 0; i < 7; i++) begin
         reg_rdata[7 - i] = cnt_r[i];
      end
      reg_rdata[wdc_pkg::WDC_ACT_BIT] = act_r;
   end

   AST_RESET_VAL: assert property (@(posedge ref_clk)
      !srst && $past(srst) |-> reg_rdata == (HW_ACTIVATION ? 8'hFF : wdc_pkg::WDC_RESET_VAL)) else $error("bad reset value");
   AST_WRITE_LOADS: assert property (@(posedge ref_clk) disable iff (srst)
      sel_wr |=> reg_rdata[7:1] == $past(reg_wdata[7:1])) else $error("write not stored");
   AST_SW_CLEAR: assert property (@(posedge ref_clk) disable iff (srst)
      act_r && sel_wr && cnt_r[6] && !reg_wdata[wdc_pkg::WDC_SR_BIT] |-> chip_reset_req) else $error("no soft reset");
   AST_NO_RESET_DISARMED: assert property (@(posedge ref_clk) disable iff (srst)
      !act_r |-> !chip_reset_req) else $error("reset while disarmed");
   AST_ARM_STICKY: assert property (@(posedge ref_clk) disable iff (srst)
      act_r |=> act_r) else $error("watchdog disarmed");
   AST_HW_ACT: assert property (@(posedge ref_clk) disable iff (srst)
      HW_ACTIVATION |-> reg_rdata[0]) else $error("hw activation bit low");
   AST_FREEZE: assert property (@(posedge ref_clk) disable iff (srst)
      frozen_r && !sel_wr |=> cnt_r == $past(cnt_r)) else $error("counter moved while frozen");
   AST_NO_STOP_HW: assert property (@(posedge ref_clk) disable iff (srst)
      act_r && !EXT_STOP_CTRL && !$past(frozen_r) |-> !frozen_r) else $error("stop granted in hw mode");
   AST_STEP: assert property (@(posedge ref_clk) disable iff (srst)
      tick && !sel_wr |=> cnt_r == $past(cnt_r) - 7'h01) else $error("bad decrement");
   // Cycles since reset or the last arming write, saturating; only the guard check reads it.
   logic [17:0] since_arm_r;
   always_ff @(posedge ref_clk) begin
      if (srst || (sel_wr && reg_wdata[wdc_pkg::WDC_ACT_BIT])) begin
         since_arm_r <= 18'h00000;
      end else if (since_arm_r != 18'h3FFFF) begin
         since_arm_r <= since_arm_r + 18'h00001;
      end
   end

   // A software-forced reset is allowed at once; only a timeout must wait a full interval.
   AST_GUARD: assert property (@(posedge ref_clk) disable iff (srst)
      chip_reset_req && !sel_wr |-> since_arm_r >= 18'(TICK_CYCLES - 1)) else $error("reset too soon after arm");

   COV_ARM: cover property (@(posedge ref_clk) disable iff (srst) $rose(act_r));
   COV_TIMEOUT: cover property (@(posedge ref_clk) disable iff (srst) chip_reset_req && tick);
   COV_SOFT: cover property (@(posedge ref_clk) disable iff (srst) chip_reset_req && sel_wr);
   COV_STOP: cover property (@(posedge ref_clk) disable iff (srst) $rose(frozen_r));
endmodule

/* File: sim/wdc_core_model.sv */
// Behavioural core that issues watchdog register writes and STOP or wake pulses.
`timescale 1ns/1ps
module wdc_core_model (
   input wire logic ref_clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic stop_req,
   output logic wake_irq
);
   initial {reg_addr, reg_wr, reg_wdata, stop_req, wake_irq} = '0;
   // The bus is inverted once released so a stale value can never pass for a fresh one.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge ref_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~v};
   endtask
   task automatic pulse(input logic wake);
      @(posedge ref_clk);
      {wake_irq, stop_req} <= {wake, ~wake};
      @(posedge ref_clk);
      {wake_irq, stop_req} <= 2'h0;
   endtask
endmodule

/* File: sim/test_watchdog_downcounter.sv */
// Self-checking bench for the watchdog downcounter driven by a behavioural core.
`timescale 1ns/1ps
module test_watchdog_downcounter;
   localparam int TK = 4;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, snap;
   logic reg_wr, stop_req, wake_irq, stop_granted, chip_reset_req, armed;
   logic [7:0] rd_hw, snap_hw;
   logic stop_hw, rst_hw, armed_hw;
   logic nmi_hw = 1'b0;
   int n_errors = 0;
   int n_compared = 0;
   int n_rst = 0;
   int c;
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (chip_reset_req === 1'b1) n_rst <= n_rst + 1;
   wdc_core_model core_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .stop_req(stop_req), .wake_irq(wake_irq));
   wdc_watchdog #(.HW_ACTIVATION(1'b0), .EXT_STOP_CTRL(1'b0), .TICK_CYCLES(TK)) dut_u (.ref_clk(ref_clk),
      .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .stop_req(stop_req), .wake_irq(wake_irq), .nmi_pin(1'b0), .stop_granted(stop_granted),
      .chip_reset_req(chip_reset_req), .armed(armed));
   wdc_watchdog #(.HW_ACTIVATION(1'b1), .EXT_STOP_CTRL(1'b1), .TICK_CYCLES(TK)) dut_hw_u (.ref_clk(ref_clk),
      .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(rd_hw),
      .stop_req(stop_req), .wake_irq(wake_irq), .nmi_pin(nmi_hw), .stop_granted(stop_hw),
      .chip_reset_req(rst_hw), .armed(armed_hw));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] enc(input logic [6:0] cnt, input logic act);
      for (int i = 0; i < 7; i++) enc[7-i] = cnt[i];
      enc[0] = act;
   endfunction
   // Reads happen 1 ns after the edge so registered updates have landed.
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic do_rst;
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      cyc(1);
   endtask
   task automatic tally_and_finish;
      $display("compared=%0d errors=%0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      do_rst();
      chk(reg_rdata, wdc_pkg::WDC_RESET_VAL);
      core_u.wr(8'hD7, 8'h00);
      // Looked at before the free timer's first tick can move the count.
      #1;
      chk(reg_rdata, wdc_pkg::WDC_RESET_VAL);
      $display("reset and map done");
      core_u.wr(8'hD8, 8'h02);
      cyc(1);
      chk(reg_rdata, enc(7'h40, 1'b0));
      cyc(TK + 1);
      chk(reg_rdata, enc(7'h3F, 1'b0));
      chk(8'(n_rst), 8'h00);
      $display("free timer done");
      do_rst();
      core_u.wr(8'hD8, 8'h03);
      core_u.wr(8'hD8, 8'h02);
      cyc(1);
      chk({7'h00, armed}, 8'h01);
      chk(reg_rdata, enc(7'h40, 1'b1));
      c = n_rst;
      core_u.wr(8'hD8, 8'hFD);
      #1;
      chk(8'(n_rst - c), 8'h01);
      do_rst();
      chk({7'h00, armed}, 8'h00);
      $display("arm and soft reset done");
      core_u.wr(8'hD8, 8'h03);
      c = 0;
      // The bound is two intervals; the first tick must already drop the top bit.
      while (n_rst == 1 && c < 2 * TK) begin
         cyc(1);
         c++;
      end
      chk(8'(n_rst), 8'h02);
      chk(8'(c >= TK - 1 && c <= TK + 1), 8'h01);
      if (n_rst != 2) tally_and_finish();
      $display("timeout done");
      do_rst();
      core_u.wr(8'hD8, 8'h02);
      core_u.pulse(1'b0);
      cyc(1);
      chk({7'h00, stop_granted}, 8'h01);
      snap = reg_rdata;
      cyc(3 * TK);
      chk(reg_rdata, snap);
      core_u.pulse(1'b1);
      cyc(2 * TK);
      chk({7'h00, stop_granted}, 8'h00);
      $display("stop done");
      do_rst();
      chk(rd_hw, 8'hFF);
      chk({7'h00, armed_hw}, 8'h01);
      core_u.wr(8'hD8, 8'h02);
      cyc(1);
      chk(rd_hw, enc(7'h40, 1'b1));
      core_u.pulse(1'b0);
      cyc(1);
      chk({7'h00, stop_hw}, 8'h00);
      @(posedge ref_clk);
      nmi_hw <= 1'b1;
      cyc(3);
      core_u.wr(8'hD8, 8'h02);
      core_u.pulse(1'b0);
      cyc(1);
      chk({7'h00, stop_hw}, 8'h01);
      snap_hw = rd_hw;
      cyc(3 * TK);
      chk(rd_hw, snap_hw);
      core_u.pulse(1'b1);
      cyc(2 * TK);
      chk({7'h00, stop_hw}, 8'h00);
      chk(8'(rd_hw != snap_hw), 8'h01);
      $display("hw option done");
      tally_and_finish();
   end
endmodule
